/* hdl/usr_defines.vh */
// constants for the serial receive-status and transmit sequencer block
// assumes the includer sets timescale and nettype itself
`ifndef USR_DEFINES_VH
`define USR_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------------
`define USR_OFS_DATA 3'h0
`define USR_OFS_RSTAT 3'h1
`define USR_OFS_TSTAT 3'h2
`define USR_OFS_CTRL 3'h3
`define USR_OFS_SYNC 3'h4

// ----------------------------------------------------------------------
// receive_status bit positions
// ----------------------------------------------------------------------
`define USR_RS_BF 7
`define USR_RS_OE 6
`define USR_RS_PE 5
`define USR_RS_FE 4
`define USR_RS_FSB 3
`define USR_RS_MCIP 2
`define USR_RS_SS 1
`define USR_RS_RE 0

// ----------------------------------------------------------------------
// transmit_status bit positions
// ----------------------------------------------------------------------
`define USR_TS_BE 7
`define USR_TS_UE 6
`define USR_TS_AT 5
`define USR_TS_END 4
`define USR_TS_BRK 3
`define USR_TS_TE 0

// ----------------------------------------------------------------------
// control bit positions
// ----------------------------------------------------------------------
`define USR_CT_SYNC 0
`define USR_CT_RXERR 1
`define USR_CT_TXBUF 2
`define USR_CT_TXERR 3
`define USR_CT_RXFULL 4

// ----------------------------------------------------------------------
// reset values and state codes
// ----------------------------------------------------------------------
`define USR_BYTE_ZERO 8'h00
`define USR_CNT_ZERO 4'h0
`define USR_CNT_ONE 4'h1
`define USR_RX_IDLE 2'h0
`define USR_RX_DATA 2'h1
`define USR_RX_STOP 2'h2
`define USR_TX_IDLE 2'h0
`define USR_TX_DATA 2'h1
`define USR_TX_STOP 2'h2
`define USR_TX_BRK 2'h3

`endif

/* hdl/usr_core.v */
// serial receive-status flags and transmit sequencer, one clock domain
// assumes link clocks and serial input are asynchronous pins that are
// synchronised here; 1x bit clock, 8-bit words, lsb first
`timescale 1ns/100ps
`default_nettype none
`include "usr_defines.vh"

module usr_core #(
  parameter DW = 8
) (
  // clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // register port
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // serial link
  input wire rx_clk_i,
  input wire tx_clk_i,
  input wire ser_in_i,
  output reg ser_out_o,
  // interrupt channels
  output reg rx_full_int_o,
  output reg rx_err_int_o,
  output reg tx_empty_int_o,
  output reg tx_err_int_o
);

  // ----------------------------------------------------------------------
  // pin synchronisers and link clock edge finders
  // ----------------------------------------------------------------------
  reg [2:0] rxc_r;
  reg [2:0] txc_r;
  reg [1:0] si_r;
  wire rx_edge = rxc_r[1] & ~rxc_r[2];
  wire tx_edge = txc_r[1] & ~txc_r[2];
  wire si = si_r[1];

  // first stage read only by second; third stage only for the edge
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rxc_r <= 3'h0;
      txc_r <= 3'h0;
      si_r <= 2'h3;
    end else begin
      rxc_r <= {rxc_r[1:0], rx_clk_i};
      txc_r <= {txc_r[1:0], tx_clk_i};
      si_r <= {si_r[0], ser_in_i};
    end
  end

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire wr_data = wr_i & (addr_i == `USR_OFS_DATA);
  wire wr_rs = wr_i & (addr_i == `USR_OFS_RSTAT);
  wire wr_ts = wr_i & (addr_i == `USR_OFS_TSTAT);
  wire wr_ct = wr_i & (addr_i == `USR_OFS_CTRL);
  wire wr_sc = wr_i & (addr_i == `USR_OFS_SYNC);
  wire rd_data = rd_i & (addr_i == `USR_OFS_DATA);
  wire rd_rs = rd_i & (addr_i == `USR_OFS_RSTAT);
  wire rd_ts = rd_i & (addr_i == `USR_OFS_TSTAT);

  reg [7:0] ctrl_r;
  reg [7:0] sync_r;
  wire sync_mode = ctrl_r[`USR_CT_SYNC];

  // control and sync character registers
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ctrl_r <= `USR_BYTE_ZERO;
      sync_r <= `USR_BYTE_ZERO;
    end else begin
      if (wr_ct)
        ctrl_r <= wdata_i;
      if (wr_sc)
        sync_r <= wdata_i;
    end
  end

  // ----------------------------------------------------------------------
  // transmitter state
  // ----------------------------------------------------------------------
  reg [1:0] tst_r;
  reg [7:0] tsh_r;
  reg [7:0] tbuf_r;
  reg [3:0] tcnt_r;
  reg be_r, ue_r, at_r, end_r, brk_r, te_r, first_r, wend_r;
  reg txb_ev_r, txe_ev_r;
  // tx disable under auto turnaround, seen by the receiver
  wire te_off = wr_ts & ~wdata_i[`USR_TS_TE] & te_r;
  wire at_off = te_off & at_r;

  // ----------------------------------------------------------------------
  // receiver state
  // ----------------------------------------------------------------------
  reg [1:0] rst_r;
  reg [7:0] rsh_r;
  reg [7:0] rbuf_r;
  reg [3:0] rcnt_r;
  reg bf_r, oe_r, fe_r, fsb_r, m_r, cip_r, ss_r, re_r;
  reg brk_line_r, brk_ack_r, brk_pend_r, ovr_pend_r;
  reg rxf_ev_r, rxe_ev_r;

  // next shifter contents on a receive bit edge, lsb first
  wire [7:0] rsh_nxt = {si, rsh_r[7:1]};
  wire rx_sync_hit = (rsh_nxt == sync_r);

  // receive path: sampling, word completion and status flags
  always @(posedge clk_sys_i) begin : rx_proc
    reg wd;
    reg [7:0] wdat;
    reg wbrk, wfe;
    wd = 1'b0;
    wdat = rsh_r;
    wbrk = 1'b0;
    wfe = 1'b0;
    if (!resetn_i) begin
      rst_r <= `USR_RX_IDLE;
      rsh_r <= `USR_BYTE_ZERO;
      rbuf_r <= `USR_BYTE_ZERO;
      rcnt_r <= `USR_CNT_ZERO;
      {bf_r, oe_r, fe_r, fsb_r, m_r, cip_r, ss_r, re_r} <= `USR_BYTE_ZERO;
      {brk_line_r, brk_ack_r, brk_pend_r, ovr_pend_r} <= 4'h0;
      rxf_ev_r <= 1'b0;
      rxe_ev_r <= 1'b0;
    end else if (!re_r) begin
      // receiver off: state idle, all flags except ss cleared
      rst_r <= `USR_RX_IDLE;
      rcnt_r <= `USR_CNT_ZERO;
      {bf_r, oe_r, fe_r, fsb_r, m_r, cip_r} <= 6'h00;
      {brk_line_r, brk_ack_r, brk_pend_r, ovr_pend_r} <= 4'h0;
      rxf_ev_r <= 1'b0;
      rxe_ev_r <= 1'b0;
      if (at_off) begin
        re_r <= 1'b1; // turnaround hands the line over
      end else if (wr_rs) begin
        ss_r <= wdata_i[`USR_RS_SS];
        re_r <= wdata_i[`USR_RS_RE];
      end
    end else begin
      rxf_ev_r <= 1'b0;
      rxe_ev_r <= 1'b0;
      // bit sampling on the receive clock
      if (rx_edge) begin
        if (si)
          brk_line_r <= 1'b0; // a one ends a break
        if (sync_mode) begin
          rsh_r <= rsh_nxt;
          if (!fsb_r) begin
            // search: compare every bit, counter held
            rcnt_r <= `USR_CNT_ZERO;
            if (rx_sync_hit) begin
              fsb_r <= 1'b1;
              rxe_ev_r <= 1'b1;
            end
          end else if (rcnt_r == DW - 1) begin
            rcnt_r <= `USR_CNT_ZERO;
            wd = 1'b1;
            wdat = rsh_nxt;
          end else begin
            rcnt_r <= rcnt_r + `USR_CNT_ONE;
          end
        end else begin
          case (rst_r)
            `USR_RX_IDLE: begin
              if (!si) begin
                cip_r <= 1'b1; // start bit seen
                rcnt_r <= `USR_CNT_ZERO;
                rst_r <= `USR_RX_DATA;
              end
            end
            `USR_RX_DATA: begin
              rsh_r <= rsh_nxt;
              rcnt_r <= rcnt_r + `USR_CNT_ONE;
              if (rcnt_r == DW - 1)
                rst_r <= `USR_RX_STOP;
            end
            `USR_RX_STOP: begin
              cip_r <= 1'b0;
              rst_r <= `USR_RX_IDLE;
              wd = 1'b1;
              wbrk = ~si & (rsh_r == `USR_BYTE_ZERO);
              wfe = ~si & (rsh_r != `USR_BYTE_ZERO);
            end
            default: begin
              rst_r <= `USR_RX_IDLE;
            end
          endcase
        end
      end
      // reading the buffer releases it and posts pending events
      if (rd_data && bf_r) begin
        bf_r <= 1'b0;
        if (brk_pend_r || ovr_pend_r) begin
          fsb_r <= brk_pend_r;
          oe_r <= ovr_pend_r;
          rxe_ev_r <= 1'b1;
        end
        brk_pend_r <= 1'b0;
        ovr_pend_r <= 1'b0;
      end
      // a status read acknowledges a pending break flag
      if (rd_rs && fsb_r && !sync_mode)
        brk_ack_r <= 1'b1;
      // break flag release and end-of-break interrupt
      if (!sync_mode && fsb_r && !brk_line_r && brk_ack_r && !wd) begin
        fsb_r <= 1'b0;
        brk_ack_r <= 1'b0;
        rxe_ev_r <= 1'b1;
      end
      // completed word: strip, overrun, break or load
      if (wd) begin
        if (wbrk) begin
          brk_line_r <= 1'b1;
          if (bf_r && !rd_data) begin
            brk_pend_r <= 1'b1; // no overrun for a break
          end else begin
            fsb_r <= 1'b1;
            brk_ack_r <= 1'b0;
            fe_r <= 1'b0;
            rxe_ev_r <= 1'b1;
          end
        end else if (sync_mode && ss_r && (wdat == sync_r)) begin
          // stripped: no load, no full condition
        end else if (bf_r && !rd_data) begin
          ovr_pend_r <= 1'b1; // flags stay frozen
        end else begin
          rbuf_r <= wdat;
          bf_r <= 1'b1;
          oe_r <= 1'b0;
          fe_r <= wfe;
          m_r <= sync_mode & (wdat == sync_r);
          if (wfe)
            rxe_ev_r <= 1'b1;
          else
            rxf_ev_r <= 1'b1;
        end
      end
      // software access to the writable status bits
      if (wr_rs) begin
        ss_r <= wdata_i[`USR_RS_SS];
        re_r <= wdata_i[`USR_RS_RE];
        if (sync_mode)
          fsb_r <= wdata_i[`USR_RS_FSB];
      end
    end
  end

  // transmit path: buffer, shifter, break and underrun sequencing
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      tst_r <= `USR_TX_IDLE;
      tsh_r <= `USR_BYTE_ZERO;
      tbuf_r <= `USR_BYTE_ZERO;
      tcnt_r <= `USR_CNT_ZERO;
      {be_r, ue_r, at_r, end_r, brk_r, te_r, first_r, wend_r} <= 8'h80;
      txb_ev_r <= 1'b0;
      txe_ev_r <= 1'b0;
      ser_out_o <= 1'b1;
    end else begin
      txb_ev_r <= 1'b0;
      txe_ev_r <= 1'b0;
      // status read clears underrun; placed first so a set wins
      if (rd_ts)
        ue_r <= 1'b0;
      if (tx_edge) begin
        case (tst_r)
          `USR_TX_IDLE: begin
            wend_r <= 1'b0;
            if (!te_r) begin
              // stopped; no underrun on the last word
              ser_out_o <= 1'b1;
              if (!end_r)
                txe_ev_r <= 1'b1;
              end_r <= 1'b1;
            end else if (first_r) begin
              ser_out_o <= 1'b1; // lead-in one bit
              first_r <= 1'b0;
            end else if (brk_r && !sync_mode) begin
              ser_out_o <= 1'b0; // break waits for word end
              tcnt_r <= `USR_CNT_ONE;
              tst_r <= `USR_TX_BRK;
            end else if (!be_r) begin
              be_r <= 1'b1;
              txb_ev_r <= 1'b1;
              tst_r <= `USR_TX_DATA;
              if (sync_mode) begin
                ser_out_o <= tbuf_r[0];
                tsh_r <= {1'b0, tbuf_r[7:1]};
                tcnt_r <= `USR_CNT_ONE;
              end else begin
                ser_out_o <= 1'b0;
                tsh_r <= tbuf_r;
                tcnt_r <= `USR_CNT_ZERO;
              end
            end else begin
              if (wend_r && !ue_r) begin
                ue_r <= 1'b1;
                txe_ev_r <= 1'b1;
              end
              if (sync_mode) begin
                // idle fill with the sync character
                ser_out_o <= sync_r[0];
                tsh_r <= {1'b0, sync_r[7:1]};
                tcnt_r <= `USR_CNT_ONE;
                tst_r <= `USR_TX_DATA;
              end else begin
                ser_out_o <= 1'b1; // mark
              end
            end
          end
          `USR_TX_DATA: begin
            ser_out_o <= tsh_r[0];
            tsh_r <= {1'b0, tsh_r[7:1]};
            tcnt_r <= tcnt_r + `USR_CNT_ONE;
            if (tcnt_r == DW - 1) begin
              tst_r <= sync_mode ? `USR_TX_IDLE : `USR_TX_STOP;
              wend_r <= sync_mode;
            end
          end
          `USR_TX_STOP: begin
            ser_out_o <= 1'b1;
            tst_r <= `USR_TX_IDLE;
            wend_r <= 1'b1;
          end
          `USR_TX_BRK: begin
            tcnt_r <= tcnt_r + `USR_CNT_ONE;
            if (tcnt_r == DW) begin
              // character boundary inside a break
              tcnt_r <= `USR_CNT_ZERO;
              txe_ev_r <= 1'b1; // end interrupt
              if (!te_r) begin
                // stop with no stop bit, buffer kept
                ser_out_o <= 1'b1;
                end_r <= 1'b1;
                tst_r <= `USR_TX_IDLE;
              end else if (!brk_r) begin
                ser_out_o <= 1'b1;
                tst_r <= `USR_TX_STOP; // then buffer or underrun
              end else begin
                ser_out_o <= 1'b0;
              end
            end else begin
              ser_out_o <= 1'b0;
            end
          end
          default: begin
            tst_r <= `USR_TX_IDLE;
          end
        endcase
      end
      // data write loads the buffer after any move this cycle
      if (wr_data) begin
        tbuf_r <= wdata_i;
        be_r <= 1'b0;
      end
      if (wr_ts) begin
        at_r <= wdata_i[`USR_TS_AT];
        brk_r <= wdata_i[`USR_TS_BRK];
        te_r <= wdata_i[`USR_TS_TE];
        if (wdata_i[`USR_TS_TE] && !te_r) begin
          first_r <= 1'b1;
          end_r <= 1'b0;
        end
        if (!wdata_i[`USR_TS_TE])
          ue_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt channel outputs and read data
  // ----------------------------------------------------------------------
  wire err_on = ctrl_r[`USR_CT_RXERR];
  wire [7:0] rs_view = {bf_r, oe_r, 1'b0, fe_r, fsb_r,
                        (sync_mode ? m_r : cip_r), ss_r, re_r};
  wire [7:0] ts_view = {be_r, ue_r, at_r, end_r, brk_r, 2'h0, te_r};

  // errors go to the full channel when the error channel is off
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rx_full_int_o <= 1'b0;
      rx_err_int_o <= 1'b0;
      tx_empty_int_o <= 1'b0;
      tx_err_int_o <= 1'b0;
      rdata_o <= `USR_BYTE_ZERO;
    end else begin
      rx_err_int_o <= rxe_ev_r & err_on;
      rx_full_int_o <= ctrl_r[`USR_CT_RXFULL] &
                       (rxf_ev_r | (rxe_ev_r & ~err_on));
      tx_empty_int_o <= txb_ev_r & ctrl_r[`USR_CT_TXBUF];
      tx_err_int_o <= txe_ev_r & ctrl_r[`USR_CT_TXERR];
      rdata_o <= `USR_BYTE_ZERO;
      if (rd_i) begin
        case (addr_i)
          `USR_OFS_DATA: rdata_o <= rbuf_r;
          `USR_OFS_RSTAT: rdata_o <= rs_view;
          `USR_OFS_TSTAT: rdata_o <= ts_view;
          `USR_OFS_CTRL: rdata_o <= ctrl_r;
          `USR_OFS_SYNC: rdata_o <= sync_r;
          default: rdata_o <= `USR_BYTE_ZERO;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* test/usr_core_monitor.sv */
// checker for the serial status and transmit core, ports only
// assumes it is bound to usr_core and shares its clock and reset
`timescale 1ns/100ps
`default_nettype none
module usr_core_monitor #(
  parameter DW = 8
) (
  // clock, reset and register port
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [2:0] addr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // link and interrupt channels
  input wire logic tx_clk_i,
  input wire logic ser_out_o,
  input wire logic rx_full_int_o,
  input wire logic rx_err_int_o,
  input wire logic tx_empty_int_o,
  input wire logic tx_err_int_o
);
  // ----------------------------------------------------------------
  // cycles since a raw rising edge of the transmit bit clock
  // ----------------------------------------------------------------
  logic txc_q;
  logic [3:0] since_r;
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      txc_q <= 1'b0;
      since_r <= 4'hf;
    end else begin
      txc_q <= tx_clk_i;
      if (!txc_q && tx_clk_i) since_r <= 4'h0;
      else if (since_r != 4'hf) since_r <= since_r + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_rd_unmapped;
    rd_i && (addr_i > 3'h4);
  endsequence
  property p_unmapped;
    s_rd_unmapped |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read gave data");
  property p_rdata_idle;
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read cycle");
  property p_rxf_pulse;
    rx_full_int_o |=> !rx_full_int_o;
  endproperty
  a_rxf_pulse: assert property (p_rxf_pulse)
    else $error("full channel pulse too long");
  property p_rxe_pulse;
    rx_err_int_o |=> !rx_err_int_o;
  endproperty
  a_rxe_pulse: assert property (p_rxe_pulse)
    else $error("error channel pulse too long");
  property p_one_chan;
    !(rx_err_int_o && rx_full_int_o);
  endproperty
  a_one_chan: assert property (p_one_chan)
    else $error("both receive channels at once");
  property p_ser_edge;
    $changed(ser_out_o) |-> since_r < 4'h7;
  endproperty
  a_ser_edge: assert property (p_ser_edge)
    else $error("line moved away from a bit edge");
  property p_txe_edge;
    tx_empty_int_o |-> (since_r < 4'ha) ##1 !tx_empty_int_o;
  endproperty
  a_txe_edge: assert property (p_txe_edge)
    else $error("vacant pulse not tied to a bit edge");
  property p_txr_edge;
    tx_err_int_o |-> (since_r < 4'ha) ##1 !tx_err_int_o;
  endproperty
  a_txr_edge: assert property (p_txr_edge)
    else $error("underrun pulse not tied to a bit edge");
endmodule
`default_nettype wire

/* test/usr_link_model.sv */
// remote serial device: free bit clocks, async frame sender and catcher
// assumes 1x bit clocks, 8 data bits lsb first, no parity
`timescale 1ns/100ps
`default_nettype none
module usr_link_model (
  // towards the core
  output logic rx_clk_o,
  output logic tx_clk_o,
  output logic ser_in_o,
  // from the core
  input wire logic ser_out_i
);
  // ----------------------------------------------------------------
  // bit clocks run free, offset from the system clock phase
  // ----------------------------------------------------------------
  initial begin
    rx_clk_o = 1'b0;
    tx_clk_o = 1'b0;
    ser_in_o = 1'b1;
    #13;
    forever #40 tx_clk_o = ~tx_clk_o;
  end
  always #40 rx_clk_o = ~rx_clk_o;

  // one frame, then back to mark so a low stop is no new start bit
  task automatic send(input logic [7:0] d, input logic stp);
    integer i;
    @(negedge rx_clk_o) ser_in_o = 1'b0;
    for (i = 0; i < 8; i++) @(negedge rx_clk_o) ser_in_o = d[i];
    @(negedge rx_clk_o) ser_in_o = stp;
    @(negedge rx_clk_o) ser_in_o = 1'b1;
  endtask
  // raw bits for the synchronous format, lsb first, no framing
  task automatic send_raw(input logic [7:0] d);
    integer i;
    for (i = 0; i < 8; i++) @(negedge rx_clk_o) ser_in_o = d[i];
  endtask
  // mark level for n bit times
  task automatic idle(input integer n);
    @(negedge rx_clk_o) ser_in_o = 1'b1;
    repeat (n) @(negedge rx_clk_o);
  endtask
  // the level at a rising edge is the bit launched one period before
  task automatic get(output logic [7:0] d, output logic stp,
                     output logic ok);
    integer i;
    ok = 1'b0;
    for (i = 0; i < 40 && !ok; i++) begin
      @(posedge tx_clk_o);
      ok = (ser_out_i === 1'b0);
    end
    for (i = 0; i < 8; i++) begin
      @(posedge tx_clk_o);
      d[i] = ser_out_i;
    end
    @(posedge tx_clk_o);
    stp = ser_out_i;
  endtask
endmodule
`default_nettype wire

/* test/tb_usr_core.sv */
// bench for the serial status and transmit core
// assumes the link model and checker are compiled before this file
`timescale 1ns/100ps
`default_nettype none
`include "usr_defines.vh"
module tb_usr_core;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  wire logic [7:0] rdata_o;
  wire logic rx_clk, tx_clk, ser_in, ser_out, rxf, rxe, txe, txu;
  integer err_total = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  logic [7:0] b;
  logic s;
  logic ok;

  always #5 clk_sys_i = ~clk_sys_i;

  usr_core #(.DW(8)) i_usr_core (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_clk_i(rx_clk),
    .tx_clk_i(tx_clk), .ser_in_i(ser_in), .ser_out_o(ser_out),
    .rx_full_int_o(rxf), .rx_err_int_o(rxe), .tx_empty_int_o(txe),
    .tx_err_int_o(txu));
  usr_link_model i_usr_link_model (.rx_clk_o(rx_clk), .tx_clk_o(tx_clk),
    .ser_in_o(ser_in), .ser_out_i(ser_out));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e,
                    input string nm);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    chk8(nm, e, rdata_o);
  endtask
  // mask bits: 1 full, 2 rx error, 4 vacant, 8 underrun/end
  task automatic wait_int(input logic [3:0] m, input string nm);
    integer i;
    logic hit;
    hit = 1'b0;
    for (i = 0; i < 400 && !hit; i++) begin
      @(negedge clk_sys_i);
      if (({txu, txe, rxe, rxf} & m) != 4'h0) hit = 1'b1;
    end
    chk8(nm, 8'h01, {7'h0, hit});
  endtask
  task automatic rx_frame(input logic [7:0] d, input logic stp,
                          input logic [3:0] m);
    fork
      i_usr_link_model.send(d, stp);
      wait_int(m, "rx int");
    join
  endtask

  // hang guard, far above the thousand or so cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test;
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rd(`USR_OFS_TSTAT, 8'h80, "tstat");
    rd(`USR_OFS_RSTAT, 8'h00, "rstat");
    rd(3'h5, 8'h00, "unmapped");
    wr(`USR_OFS_CTRL, 8'h1e);
    $display("test reset done");
    // buffer loaded before enable, second word written in flight
    wr(`USR_OFS_DATA, 8'ha5);
    wr(`USR_OFS_TSTAT, 8'h01);
    fork
      begin
        i_usr_link_model.get(b, s, ok);
        chk8("tx start", 8'h01, {7'h0, ok});
        chk8("tx word 1", 8'ha5, b);
      end
      begin
        wait_int(4'h4, "vacant int");
        wr(`USR_OFS_DATA, 8'h3c);
      end
    join
    i_usr_link_model.get(b, s, ok);
    chk8("tx word 2", 8'h3c, b);
    chk8("tx stop", 8'h01, {7'h0, s});
    wait_int(4'h8, "underrun int");
    rd(`USR_OFS_TSTAT, 8'hc1, "tstat underrun");
    rd(`USR_OFS_TSTAT, 8'h81, "tstat read");
    chk8("idle mark", 8'h01, {7'h0, ser_out});
    $display("test transmit done");
    // clocks already run before the receiver is switched on
    wr(`USR_OFS_RSTAT, 8'h01);
    rx_frame(8'h5a, 1'b1, 4'h1);
    rd(`USR_OFS_RSTAT, 8'h81, "rstat full");
    rd(`USR_OFS_DATA, 8'h5a, "rx word");
    rx_frame(8'h12, 1'b0, 4'h2);
    i_usr_link_model.idle(2);
    rd(`USR_OFS_RSTAT, 8'h91, "rstat frame");
    rd(`USR_OFS_DATA, 8'h12, "rx word fe");
    rx_frame(8'h7e, 1'b1, 4'h1);
    rd(`USR_OFS_RSTAT, 8'h81, "rstat fe clear");
    rd(`USR_OFS_DATA, 8'h7e, "rx word 3");
    rx_frame(8'h00, 1'b0, 4'h2);
    rd(`USR_OFS_RSTAT, 8'h09, "rstat break");
    fork
      i_usr_link_model.idle(4);
      wait_int(4'h2, "break end int");
    join
    rd(`USR_OFS_RSTAT, 8'h01, "rstat break end");
    $display("test receive done");
    // receiver off with a flag up, then auto turnaround
    rx_frame(8'h12, 1'b0, 4'h2);
    i_usr_link_model.idle(2);
    wr(`USR_OFS_RSTAT, 8'h00);
    rd(`USR_OFS_RSTAT, 8'h00, "rstat off");
    wr(`USR_OFS_TSTAT, 8'h21);
    wr(`USR_OFS_TSTAT, 8'h00);
    wait_int(4'h8, "end int");
    rd(`USR_OFS_RSTAT, 8'h01, "rstat at");
    rd(`USR_OFS_TSTAT, 8'h90, "tstat end");
    $display("test disable done");
    // synchronous search, found, then a matching word loaded
    wr(`USR_OFS_CTRL, 8'h1f);
    wr(`USR_OFS_SYNC, 8'h96);
    fork
      begin
        i_usr_link_model.send_raw(8'h96);
        i_usr_link_model.send_raw(8'h96);
      end
      wait_int(4'h2, "sync found");
    join
    i_usr_link_model.idle(1);
    rd(`USR_OFS_RSTAT, 8'h8d, "rstat match");
    rd(`USR_OFS_DATA, 8'h96, "rx sync word");
    $display("test sync done");
    stop_test;
  end
endmodule

bind usr_core usr_core_monitor #(.DW(DW)) i_usr_core_monitor (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .tx_clk_i(tx_clk_i),
  .ser_out_o(ser_out_o), .rx_full_int_o(rx_full_int_o),
  .rx_err_int_o(rx_err_int_o), .tx_empty_int_o(tx_empty_int_o),
  .tx_err_int_o(tx_err_int_o));
`default_nettype wire
